// ===== logic/dsl_sync.sv
`timescale 1ns/1ps

// ============================================================
// shared constants
package dsl_pkg;

	localparam int FRAME_W = 24;
	localparam int DATA_W  = 18;
	localparam int IDX_W   = 5;

	// write word layout: command nibble on top, data right aligned
	localparam int CMD_HI   = 23;
	localparam int CMD_LO   = 20;
	localparam int DATA_HI  = 17;
	localparam int DATA_LO  = 0;
	localparam int TWOS_BIT = 0;

	localparam logic [3:0] CMD_WR_INPUT = 4'h1;
	localparam logic [3:0] CMD_WR_CLEAR = 4'h2;
	localparam logic [3:0] CMD_WR_CTRL  = 4'h3;
	localparam logic [3:0] CMD_READ     = 4'h4;

	localparam logic [17:0] DATA_RST    = 18'h00000;
	localparam logic [17:0] CLRCODE_RST = 18'h00000;
	localparam logic [23:0] WORD_RST    = 24'h000000;
	localparam logic        TWOS_RST    = 1'b0;
	localparam logic [4:0]  IDX_RST     = 5'h00;
	localparam logic [4:0]  IDX_LAST    = 5'h17;

	// reset levels of the pin samplers; the pins idle high
	localparam logic [2:0]  PIN_RST     = 3'h7;

endpackage

// ============================================================
// two flip-flop synchroniser for pin levels
module dsl_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,    // destination clock
	input  wire logic         rstn,   // async reset, active low
	input  wire logic [W-1:0] d,      // asynchronous levels
	output logic      [W-1:0] q       // synchronised levels
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb begin
		meta_d = d;
		q_d    = meta_q;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= RST;
			q      <= RST;
		end else begin
			meta_q <= meta_d;
			q      <= q_d;
		end
	end
endmodule

// ===== logic/dsl_top.sv
`timescale 1ns/1ps

module dsl_top
	import dsl_pkg::*;
(
	input  wire logic              ref_clk,           // core clock, 20 MHz
	input  wire logic              resetn,            // async reset, active low
	input  wire logic              sclk,              // serial link clock
	input  wire logic              sync_n,            // frame select, active low
	input  wire logic              serial_in,         // serial write data
	input  wire logic              load_output_n,     // load strobe, active low
	input  wire logic              clear_to_preset_n, // clear, active low
	output logic                   serial_out,        // readback data
	output logic                   serial_out_oe,     // readback drive enable
	output logic [DATA_W-1:0]      dac_code,          // code to converter core
	output logic [DATA_W-1:0]      input_code         // pending input register
);

	// ============================================================
	// helpers

	// the converter core takes offset binary; two's complement
	// words need the sign bit flipped to land on the same scale
	function automatic logic [DATA_W-1:0] to_core(
		input logic [DATA_W-1:0] code,
		input logic              twos
	);
		logic [DATA_W-1:0] flip;
		flip = '0;
		flip[DATA_W-1] = twos;
		return code ^ flip;
	endfunction

	function automatic logic [DATA_W-1:0] word_data(input logic [FRAME_W-1:0] w);
		return w[DATA_HI:DATA_LO];
	endfunction

	// ============================================================
	// link side: write shift register, falling edges of sclk

	logic [FRAME_W-1:0] rx_shift_q;
	logic [FRAME_W-1:0] rx_shift_d;

	always_comb begin
		rx_shift_d = rx_shift_q;
		if (!sync_n) begin
			rx_shift_d = {rx_shift_q[FRAME_W-2:0], serial_in};
		end
	end

	always_ff @(negedge sclk or negedge resetn) begin
		if (!resetn) begin
			rx_shift_q <= WORD_RST;
		end else begin
			rx_shift_q <= rx_shift_d;
		end
	end

	// ============================================================
	// link side: readback driver, rising edges of sclk

	// the frame select itself ends the readback: the link clock
	// may stop after the last bit, so no edge is relied on
	logic             link_rstn;
	logic [IDX_W-1:0] tx_idx_q;
	logic [IDX_W-1:0] tx_idx_d;
	logic             serial_out_d;
	logic             serial_out_oe_d;
	logic             rb_arm_q;
	logic [FRAME_W-1:0] rb_word_q;

	assign link_rstn = resetn & ~sync_n;

	always_comb begin
		tx_idx_d        = tx_idx_q;
		serial_out_d    = serial_out;
		serial_out_oe_d = serial_out_oe;
		// rb_arm_q and rb_word_q only change between frames, while
		// frame select is high and this logic is held in reset
		if (rb_arm_q) begin
			serial_out_oe_d = 1'b1;
			serial_out_d    = rb_word_q[IDX_LAST - tx_idx_q];
			if (tx_idx_q != IDX_LAST) begin
				tx_idx_d = tx_idx_q + 5'h01;
			end
		end
	end

	always_ff @(posedge sclk or negedge link_rstn) begin
		if (!link_rstn) begin
			tx_idx_q      <= IDX_RST;
			serial_out    <= 1'b0;
			serial_out_oe <= 1'b0;
		end else begin
			tx_idx_q      <= tx_idx_d;
			serial_out    <= serial_out_d;
			serial_out_oe <= serial_out_oe_d;
		end
	end

	// ============================================================
	// pin sampling into the ref_clk domain

	logic [2:0] pins_s;
	logic       s_sync_n;
	logic       s_load_n;
	logic       s_clr_n;

	dsl_sync #(
		.W   (3),
		.RST (PIN_RST)
	) u_pins (
		.clk  (ref_clk),
		.rstn (resetn),
		.d    ({sync_n, load_output_n, clear_to_preset_n}),
		.q    (pins_s)
	);

	assign s_sync_n = pins_s[2];
	assign s_load_n = pins_s[1];
	assign s_clr_n  = pins_s[0];

	// ============================================================
	// core registers, ref_clk domain

	logic              sync_prev_q;
	logic              load_prev_q;
	logic [DATA_W-1:0] input_q;
	logic [DATA_W-1:0] dac_q;
	logic [DATA_W-1:0] clr_code_q;
	logic              twos_q;

	logic              sync_prev_d;
	logic              load_prev_d;
	logic [DATA_W-1:0] input_d;
	logic [DATA_W-1:0] dac_d;
	logic [DATA_W-1:0] clr_code_d;
	logic              twos_d;
	logic              rb_arm_d;
	logic [FRAME_W-1:0] rb_word_d;
	logic [DATA_W-1:0] dac_code_d;

	logic              frame_end;
	logic              load_fall;
	logic [3:0]        rx_cmd;
	logic [DATA_W-1:0] rx_data;

	// the shift register is still when this is seen: frame select
	// has been high for two ref_clk cycles and sclk edges are ignored
	assign frame_end = s_sync_n & ~sync_prev_q;
	assign load_fall = ~s_load_n & load_prev_q;
	assign rx_cmd    = rx_shift_q[CMD_HI:CMD_LO];
	assign rx_data   = word_data(rx_shift_q);

	always_comb begin
		sync_prev_d = s_sync_n;
		load_prev_d = s_load_n;
		input_d     = input_q;
		dac_d       = dac_q;
		clr_code_d  = clr_code_q;
		twos_d      = twos_q;
		rb_arm_d    = rb_arm_q;
		rb_word_d   = rb_word_q;

		if (load_fall) begin
			dac_d = input_q;
		end

		if (frame_end) begin
			rb_arm_d = 1'b0;
			unique case (rx_cmd)
				CMD_WR_INPUT: begin
					input_d = rx_data;
					if (!s_load_n) begin
						dac_d = rx_data;
					end
				end
				CMD_WR_CLEAR: begin
					clr_code_d = rx_data;
				end
				CMD_WR_CTRL: begin
					twos_d = rx_shift_q[TWOS_BIT];
				end
				CMD_READ: begin
					rb_arm_d  = 1'b1;
					rb_word_d = {CMD_READ, 2'b00, dac_q};
				end
				default: begin
					// unknown commands are dropped
				end
			endcase
		end

		// clear overrides any load in the same cycle
		if (!s_clr_n) begin
			dac_d = clr_code_q;
		end

		dac_code_d = to_core(dac_q, twos_q);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync_prev_q <= 1'b1;
			load_prev_q <= 1'b1;
			input_q     <= DATA_RST;
			dac_q       <= DATA_RST;
			clr_code_q  <= CLRCODE_RST;
			twos_q      <= TWOS_RST;
			rb_arm_q    <= 1'b0;
			rb_word_q   <= WORD_RST;
			dac_code    <= DATA_RST;
			input_code  <= DATA_RST;
		end else begin
			sync_prev_q <= sync_prev_d;
			load_prev_q <= load_prev_d;
			input_q     <= input_d;
			dac_q       <= dac_d;
			clr_code_q  <= clr_code_d;
			twos_q      <= twos_d;
			rb_arm_q    <= rb_arm_d;
			rb_word_q   <= rb_word_d;
			dac_code    <= dac_code_d;
			input_code  <= input_d;
		end
	end

	// ============================================================
	// checks

	a_clear_forces_code: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!s_clr_n |=> dac_q == $past(clr_code_q)
	) else $error("clear did not load the clear code");

	a_output_coding: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!s_clr_n ##1 !s_clr_n |=>
			dac_code == to_core($past(clr_code_q, 2), $past(twos_q, 2))
	) else $error("output code does not follow coding select");

	a_frame_load_low: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		frame_end && rx_cmd == CMD_WR_INPUT && !s_load_n && s_clr_n
			|=> dac_q == $past(rx_data) ##1 dac_code == to_core($past(dac_q), twos_q)
	) else $error("frame end with load low did not update output");

	a_frame_hold_high: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		frame_end && s_load_n && s_clr_n && !load_fall |=> $stable(dac_q)
	) else $error("output changed with load held high");

	a_input_capture: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		frame_end && rx_cmd == CMD_WR_INPUT |=> input_q == $past(rx_data)
	) else $error("input register missed the write word");

	a_load_fall_copy: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		load_fall && !frame_end && s_clr_n |=> dac_q == $past(input_q)
	) else $error("load falling edge did not copy input register");

	a_quiet_hold: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!frame_end && !load_fall && s_clr_n |=> $stable(dac_q)
	) else $error("converter register changed without cause");

	a_shift_in: assert property (
		@(negedge sclk) disable iff (!resetn)
		!sync_n |=> rx_shift_q[0] == $past(serial_in)
			&& rx_shift_q[FRAME_W-1:1] == $past(rx_shift_q[FRAME_W-2:0])
	) else $error("serial bit not shifted in");

	a_idle_no_shift: assert property (
		@(negedge sclk) disable iff (!resetn)
		sync_n |=> $stable(rx_shift_q)
	) else $error("shift register moved outside a frame");

	a_readback_drive: assert property (
		@(posedge sclk) disable iff (!link_rstn)
		rb_arm_q && tx_idx_q == IDX_RST |=> serial_out_oe && serial_out == rb_word_q[FRAME_W-1]
	) else $error("readback first bit not driven");

	a_readback_step: assert property (
		@(posedge sclk) disable iff (!link_rstn)
		rb_arm_q && tx_idx_q != IDX_LAST |=> tx_idx_q == $past(tx_idx_q) + 5'h01
	) else $error("readback bit index did not advance");

endmodule

// ===== testbench/dsl_host_model.sv
`timescale 1ns/1ps

// ============================================================
// host serial master; sclk parks low between frames, 30 ns period
module dsl_host_model (
	output logic      sclk,       // serial clock
	output logic      sync_n,     // frame select
	output logic      serial_in,  // write data
	input  wire logic serial_out,    // readback data
	input  wire logic serial_out_oe  // readback drive enable
);
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		serial_in = 1'b0;
	end

	// data moves 5 ns after each fall so it never races the sampling edge
	task automatic send(input logic [23:0] w, output logic [23:0] rb);
		// one stray clock pulse with frame select high must shift nothing
		#5 sclk = 1'b1;
		#15 sclk = 1'b0;
		#10 sync_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			#5 serial_in = w[i];
			#10 sclk = 1'b1;
			#15 sclk = 1'b0;
			// a released pin reads back inverted, so a lost drive enable shows
			rb[i] = serial_out_oe ? serial_out : ~serial_out;
		end
		#5 sync_n = 1'b1;
		serial_in = ~w[0];
		#250;
	endtask
endmodule

// ===== testbench/dsl_top_tb_top.sv
`timescale 1ns/1ps

// ============================================================
// bench top
module dsl_top_tb_top;
	import dsl_pkg::*;

	logic              ref_clk, resetn, load_output_n, clear_to_preset_n;
	logic              sclk, sync_n, serial_in, serial_out, serial_out_oe;
	logic [DATA_W-1:0] dac_code, input_code;
	logic [23:0]       rb;
	logic [31:0]       seed;
	int                err_total, check_count, in_m, dac_m, clr_m, twos_m;

	dsl_top DUT (.ref_clk(ref_clk), .resetn(resetn), .sclk(sclk), .sync_n(sync_n),
		.serial_in(serial_in), .load_output_n(load_output_n),
		.clear_to_preset_n(clear_to_preset_n), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .dac_code(dac_code), .input_code(input_code));
	dsl_host_model u_host (.sclk(sclk), .sync_n(sync_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// core sees offset binary: two's complement coding flips the sign bit
	function automatic logic [23:0] core(input int c);
		return 24'(twos_m != 0 ? (c ^ 'h20000) : c);
	endfunction

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: %0s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask

	task automatic wr(input int cmd, input int data);
		u_host.send({cmd[3:0], 2'b00, data[17:0]}, rb);
		if (cmd == 1) in_m = data;
		if (cmd == 1 && load_output_n == 1'b0) dac_m = data;
		if (cmd == 2) clr_m = data;
		if (cmd == 3) twos_m = data & 1;
		cyc(8);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		$display("ERROR %0t: watchdog expired", $time);
		test_done;
	end

	initial begin
		resetn = 1'b0;
		load_output_n = 1'b0;
		clear_to_preset_n = 1'b1;
		seed = 32'hBD5027FA;
		{in_m, dac_m, clr_m, twos_m, err_total, check_count} = '0;
		cyc(5);
		resetn = 1'b1;
		cyc(3);
		chk(24'(dac_code), 24'h0, "reset dac");
		chk(24'(input_code), 24'h0, "reset input");
		chk(24'(serial_out_oe), 24'h0, "reset oe");
		$display("test reset done");
		repeat (4) begin
			seed = lfsr(seed);
			wr(1, seed[17:0]);
			chk(24'(dac_code), core(dac_m), "direct load");
		end
		$display("test direct load done");
		load_output_n = 1'b1;
		seed = lfsr(seed);
		wr(1, seed[17:0]);
		chk(24'(input_code), 24'(in_m), "deferred input");
		chk(24'(dac_code), core(dac_m), "held output");
		load_output_n = 1'b0;
		cyc(3);
		load_output_n = 1'b1;
		dac_m = in_m;
		cyc(6);
		chk(24'(dac_code), core(dac_m), "load pulse");
		$display("test deferred load done");
		seed = lfsr(seed);
		wr(2, seed[17:0]);
		wr(3, 1);
		chk(24'(dac_code), core(dac_m), "twos coding");
		clear_to_preset_n = 1'b0;
		cyc(6);
		dac_m = clr_m;
		chk(24'(dac_code), core(dac_m), "clear");
		clear_to_preset_n = 1'b1;
		cyc(3);
		$display("test clear done");
		wr(4, 0);
		wr(0, 0);
		chk(rb, {6'h10, 18'(dac_m)}, "readback");
		chk(24'(serial_out_oe), 24'h0, "oe off");
		$display("test readback done");
		resetn = 1'b0;
		{in_m, dac_m, clr_m, twos_m} = '0;
		load_output_n = 1'b0;
		cyc(2);
		chk(24'(dac_code), 24'h0, "rerun dac");
		chk(24'(input_code), 24'h0, "rerun input");
		resetn = 1'b1;
		cyc(3);
		seed = lfsr(seed);
		wr(1, seed[17:0]);
		chk(24'(dac_code), core(dac_m), "rerun load");
		$display("test second reset done");
		test_done;
	end
endmodule
